// ==== inc/isdc_pkg.sv ====
// constants and types of the speed detect configuration bank
package isdc_pkg;

   // -------------------------------------------------
   // register map
   // -------------------------------------------------
   localparam logic [19:0] ISDC_CFG_ADDR  = 20'h00080;
   localparam logic [31:0] ISDC_CFG_RESET = 32'h00000000;
   localparam logic [31:0] ISDC_CFG_WMASK = 32'h7FDFFFFF;

   // -------------------------------------------------
   // field positions
   // -------------------------------------------------
   localparam int ISDC_DET_EN_POS   = 30;
   localparam int ISDC_BRK_EN_POS   = 29;
   localparam int ISDC_COAST_EN_POS = 28;
   localparam int ISDC_REV_EN_POS   = 27;
   localparam int ISDC_RSY_EN_POS   = 26;
   localparam int ISDC_RSY_THR_LSB  = 22;
   localparam int ISDC_BLANK_LSB    = 17;
   localparam int ISDC_START_BRAKE_DURATION_LSB = 13;
   localparam int ISDC_CST_TIME_LSB = 9;
   localparam int ISDC_EMF_THR_LSB  = 6;
   localparam int ISDC_HAND_LSB     = 2;
   localparam int ISDC_CUR_LSB      = 0;

   // -------------------------------------------------
   // link framing
   // -------------------------------------------------
   localparam int         ISDC_CW_RD_POS   = 23;
   localparam int         ISDC_CW_CRC_POS  = 22;
   localparam int         ISDC_CW_DLEN_LSB = 20;
   localparam logic [7:0] ISDC_CRC_POLY    = 8'h07;
   localparam logic [7:0] ISDC_CRC_INIT    = 8'h00;
   localparam logic [7:0] ISDC_IDLE_BYTE   = 8'hFF;
   localparam logic [3:0] ISDC_CW_BYTES    = 4'h3;

   // -------------------------------------------------
   // decode tables
   // -------------------------------------------------
   localparam logic [13:0] ISDC_TIME_MS [16] = '{14'h000A, 14'h0032, 14'h0064, 14'h00C8,
      14'h012C, 14'h0190, 14'h01F4, 14'h02EE, 14'h03E8, 14'h07D0, 14'h0BB8, 14'h0FA0,
      14'h1388, 14'h1D4C, 14'h2710, 14'h3A98};
   localparam logic [11:0] ISDC_EMF_MV [8] = '{12'h064, 12'h096, 12'h0C8, 12'h1F4,
      12'h3E8, 12'h5DC, 12'h7D0, 12'hBB8};
   localparam logic [6:0] ISDC_RSY_PCT [16] = '{7'h05, 7'h0A, 7'h0F, 7'h14, 7'h19, 7'h1E,
      7'h23, 7'h28, 7'h2D, 7'h32, 7'h37, 7'h3C, 7'h46, 7'h50, 7'h5A, 7'h64};
   localparam logic [9:0] ISDC_HAND_PERMIL [16] = '{10'h019, 10'h032, 10'h04B, 10'h064,
      10'h07D, 10'h096, 10'h0C8, 10'h0FA, 10'h12C, 10'h190, 10'h1F4, 10'h258, 10'h2BC,
      10'h320, 10'h384, 10'h3E8};
   localparam logic [5:0] ISDC_CUR_PCT [4] = '{6'h0F, 6'h19, 6'h23, 6'h32};

   // -------------------------------------------------
   // types
   // -------------------------------------------------
   typedef enum logic [4:0]
   {
      ISDC_ST_IDLE = 5'h01,
      ISDC_ST_RX   = 5'h02,
      ISDC_ST_ACK  = 5'h04,
      ISDC_ST_TX   = 5'h08,
      ISDC_ST_TACK = 5'h10
   } isdc_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } isdc_pin_t;

   typedef struct packed {
      logic       speed_detect_enable;
      logic       brake_enable;
      logic       start_coast_enable;
      logic       reverse_drive_enable;
      logic       resynchronize_enable;
      logic [3:0] resync_speed_threshold;
      logic [3:0] current_sample_blanking;
      logic [3:0] start_brake_duration;
      logic [3:0] start_coast_duration;
      logic [2:0] stationary_emf_threshold;
      logic [3:0] reverse_openloop_handoff_speed;
      logic [1:0] reverse_openloop_current_limit;
   } isdc_cfg_t;

   typedef struct packed {
      logic [13:0] brake_ms;
      logic [13:0] coast_ms;
      logic [11:0] stationary_mv;
      logic [6:0]  resync_pct;
      logic [9:0]  handoff_permil;
      logic [5:0]  current_pct;
   } isdc_dec_t;

endpackage

// ==== hw/isdc_sync.sv ====
// two-stage synchroniser for asynchronous pin levels
module isdc_sync #(
   parameter int W = 2
) (
   input  wire logic         sys_clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   // -------------------------------------------------
   // state
   // -------------------------------------------------
   logic [1:0][W-1:0] stage_q;
   logic [1:0][W-1:0] stage_d;

   always_comb
   begin
      stage_d[0] = async_i;
      stage_d[1] = stage_q[0];
   end

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
         stage_q <= '1;
      else
         stage_q <= stage_d;
   end

   assign sync_o = stage_q[1];

endmodule

// ==== hw/isdc_top.sv ====
// speed detect configuration register with its two-wire target port
// -------------------------------------------------
// Overview of operation
// - register at 80h, resets to zero
// - bit 30 enables initial speed detection
// - bit 29 enables start braking
// - bit 28 enables start coast
// - bit 27 reverse drive, 26 resync enable
// - bits 25:22 resync speed, 5 to 100%
// - bits 20:17 current sample blanking time
// - bits 16:13 brake time, 10ms to 15s
// - bits 12:9 coast time, same table
// - bits 8:6 stationary emf, 100-3000mV
// - bits 5:2 reverse handoff, 2.5-100%
// - bits 1:0 reverse current 15-50%
// - framed by id, control word, data, crc
// -------------------------------------------------
module isdc_top #(
   parameter logic [6:0] TARGET_ID = 7'h01
) (
   input  wire logic              sys_clk_i,
   input  wire logic              reset_i,
   input  wire isdc_pkg::isdc_pin_t i2c_i,
   output logic                   sda_o,
   output logic                   sda_oe_o,
   output isdc_pkg::isdc_cfg_t    cfg_o,
   output isdc_pkg::isdc_dec_t    dec_o
);
   import isdc_pkg::*;

   // -------------------------------------------------
   // state
   // -------------------------------------------------
   typedef struct packed {
      isdc_state_t state;
      logic        scl;
      logic        sda;
      logic [7:0]  shift;
      logic [3:0]  bit_cnt;
      logic [3:0]  byte_cnt;
      logic        is_read;
      logic        ack;
      logic        rd_pend;
      logic [23:0] cw;
      logic [31:0] data;
      logic [7:0]  crc;
      logic [7:0]  crc_cw;
      logic        crc_ok;
      logic        sda_drv;
      logic [31:0] cfg;
      isdc_dec_t   dec;
   } isdc_regs_t;

   isdc_regs_t r_q;
   isdc_regs_t r_d;
   isdc_pin_t  pin_s;

   // -------------------------------------------------
   // pin synchroniser
   // -------------------------------------------------
   isdc_sync #(
      .W (2)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .async_i   (i2c_i),
      .sync_o    (pin_s)
   );

   // -------------------------------------------------
   // crc step, x^8 + x^2 + x + 1
   // -------------------------------------------------
   function automatic logic [7:0] isdc_crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++)
         x = x[7] ? ({x[6:0], 1'b0} ^ ISDC_CRC_POLY) : {x[6:0], 1'b0};
      return x;
   endfunction

   // -------------------------------------------------
   // next state
   // -------------------------------------------------
   logic       rise;
   logic       fall;
   logic       start_c;
   logic       stop_c;
   logic       crc_en;
   logic [1:0] dlen;
   logic [4:0] dbytes;
   logic [4:0] need;
   logic       at_cfg;
   logic [3:0] idx;
   logic [7:0] tx_byte;
   logic       tx_data;
   logic       do_load;
   logic [7:0] b;

   always_comb
   begin
      r_d     = r_q;
      b       = r_q.shift;
      rise    = pin_s.scl & ~r_q.scl;
      fall    = ~pin_s.scl & r_q.scl;
      start_c = pin_s.scl & r_q.scl & r_q.sda & ~pin_s.sda;
      stop_c  = pin_s.scl & r_q.scl & ~r_q.sda & pin_s.sda;
      crc_en  = r_q.cw[ISDC_CW_CRC_POS];
      dlen    = r_q.cw[ISDC_CW_DLEN_LSB +: 2];
      dbytes  = 5'h02 << dlen;
      need    = 5'h04 + dbytes + {4'h0, crc_en};
      // other offsets are not served: reads give zero, writes are dropped
      at_cfg  = (r_q.cw[19:0] == ISDC_CFG_ADDR);
      do_load = 1'b0;
      r_d.scl = pin_s.scl;
      r_d.sda = pin_s.sda;

      // outgoing byte: register data, then crc when asked for
      idx     = r_q.byte_cnt - 4'h1;
      tx_data = ({1'b0, idx} < dbytes);
      if (tx_data)
         tx_byte = (at_cfg && idx < 4'h4) ? r_q.cfg[{idx[1:0], 3'h0} +: 8] : 8'h00;
      else if (crc_en)
         tx_byte = r_q.crc;
      else
         tx_byte = ISDC_IDLE_BYTE;

      if (start_c)
      begin
         r_d.state    = ISDC_ST_RX;
         r_d.bit_cnt  = 4'h0;
         r_d.byte_cnt = 4'h0;
         r_d.sda_drv  = 1'b0;
      end
      else if (stop_c)
      begin
         // write commits only on a whole frame, with its crc checked only when the control word enables crc
         if (!r_q.is_read && !r_q.cw[ISDC_CW_RD_POS] && at_cfg && dlen != 2'h0 && dlen != 2'h3
             && {1'b0, r_q.byte_cnt} == need && (r_q.crc_ok || !crc_en))
            r_d.cfg = r_q.data & ISDC_CFG_WMASK;
         r_d.state   = ISDC_ST_IDLE;
         r_d.sda_drv = 1'b0;
      end
      else
      begin
         unique case (r_q.state)
            ISDC_ST_IDLE:
            begin
               r_d.sda_drv = 1'b0;
            end
            ISDC_ST_RX:
            begin
               if (rise)
               begin
                  r_d.shift   = {r_q.shift[6:0], pin_s.sda};
                  r_d.bit_cnt = r_q.bit_cnt + 4'h1;
               end
               else if (fall && r_q.bit_cnt == 4'h8)
               begin
                  r_d.ack     = 1'b1;
                  r_d.bit_cnt = 4'h0;
                  if (r_q.byte_cnt != 4'hF)
                     r_d.byte_cnt = r_q.byte_cnt + 4'h1;
                  if (r_q.byte_cnt == 4'h0)
                  begin
                     // target id and direction
                     r_d.is_read = b[0];
                     if (b[7:1] != TARGET_ID)
                        r_d.ack = 1'b0;
                     else if (!b[0])
                     begin
                        r_d.crc    = isdc_crc8(ISDC_CRC_INIT, b);
                        r_d.crc_ok = 1'b0;
                     end
                     else if (r_q.rd_pend)
                        r_d.crc = isdc_crc8(r_q.crc_cw, b);
                     else
                        r_d.ack = 1'b0;
                  end
                  else if (r_q.byte_cnt <= ISDC_CW_BYTES)
                  begin
                     // control word, most significant byte first
                     r_d.cw  = {r_q.cw[15:0], b};
                     r_d.crc = isdc_crc8(r_q.crc, b);
                     if (r_q.byte_cnt == ISDC_CW_BYTES)
                     begin
                        r_d.rd_pend = r_q.cw[15];
                        r_d.crc_cw  = isdc_crc8(r_q.crc, b);
                        r_d.data    = 32'h00000000;
                     end
                  end
                  else if ({1'b0, r_q.byte_cnt} < 5'h04 + dbytes)
                  begin
                     // data bytes, least significant first
                     if (r_q.byte_cnt < 4'h8)
                        r_d.data[{r_q.byte_cnt[1:0], 3'h0} +: 8] = b;
                     r_d.crc = isdc_crc8(r_q.crc, b);
                  end
                  else if ({1'b0, r_q.byte_cnt} == 5'h04 + dbytes)
                     r_d.crc_ok = (b == r_q.crc);
                  r_d.sda_drv = r_d.ack;
                  r_d.state   = ISDC_ST_ACK;
               end
            end
            ISDC_ST_ACK:
            begin
               if (fall)
               begin
                  r_d.sda_drv = 1'b0;
                  if (!r_q.ack)
                     r_d.state = ISDC_ST_IDLE;
                  else if (r_q.is_read)
                     do_load = 1'b1;
                  else
                     r_d.state = ISDC_ST_RX;
               end
            end
            ISDC_ST_TX:
            begin
               if (fall)
               begin
                  if (r_q.bit_cnt == 4'h7)
                  begin
                     r_d.sda_drv = 1'b0;
                     r_d.state   = ISDC_ST_TACK;
                  end
                  else
                  begin
                     r_d.shift   = {r_q.shift[6:0], 1'b0};
                     r_d.sda_drv = ~r_q.shift[6];
                     r_d.bit_cnt = r_q.bit_cnt + 4'h1;
                  end
               end
            end
            ISDC_ST_TACK:
            begin
               if (rise)
               begin
                  r_d.ack = ~pin_s.sda;
                  // a not-acknowledge closes the pending read
                  if (pin_s.sda)
                     r_d.rd_pend = 1'b0;
               end
               else if (fall)
               begin
                  if (r_q.ack)
                     do_load = 1'b1;
                  else
                     r_d.state = ISDC_ST_IDLE;
               end
            end
         endcase
      end

      // load next outgoing byte
      if (do_load)
      begin
         r_d.shift   = tx_byte;
         r_d.sda_drv = ~tx_byte[7];
         r_d.bit_cnt = 4'h0;
         r_d.state   = ISDC_ST_TX;
         if (tx_data)
            r_d.crc = isdc_crc8(r_q.crc, tx_byte);
         if (r_q.byte_cnt != 4'hF)
            r_d.byte_cnt = r_q.byte_cnt + 4'h1;
      end

      // decoded settings for the start sequence
      r_d.dec.brake_ms       = ISDC_TIME_MS[r_d.cfg[ISDC_START_BRAKE_DURATION_LSB +: 4]];
      r_d.dec.coast_ms       = ISDC_TIME_MS[r_d.cfg[ISDC_CST_TIME_LSB +: 4]];
      r_d.dec.stationary_mv  = ISDC_EMF_MV[r_d.cfg[ISDC_EMF_THR_LSB +: 3]];
      r_d.dec.resync_pct     = ISDC_RSY_PCT[r_d.cfg[ISDC_RSY_THR_LSB +: 4]];
      r_d.dec.handoff_permil = ISDC_HAND_PERMIL[r_d.cfg[ISDC_HAND_LSB +: 4]];
      r_d.dec.current_pct    = ISDC_CUR_PCT[r_d.cfg[ISDC_CUR_LSB +: 2]];
   end

   // -------------------------------------------------
   // registers
   // -------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         r_q                    <= '0;
         r_q.state              <= ISDC_ST_IDLE;
         r_q.scl                <= 1'b1;
         r_q.sda                <= 1'b1;
         r_q.crc                <= ISDC_CRC_INIT;
         r_q.crc_cw             <= ISDC_CRC_INIT;
         r_q.cfg                <= ISDC_CFG_RESET;
         r_q.dec.brake_ms       <= ISDC_TIME_MS[0];
         r_q.dec.coast_ms       <= ISDC_TIME_MS[0];
         r_q.dec.stationary_mv  <= ISDC_EMF_MV[0];
         r_q.dec.resync_pct     <= ISDC_RSY_PCT[0];
         r_q.dec.handoff_permil <= ISDC_HAND_PERMIL[0];
         r_q.dec.current_pct    <= ISDC_CUR_PCT[0];
      end
      else
         r_q <= r_d;
   end

   // -------------------------------------------------
   // outputs
   // -------------------------------------------------
   assign sda_o    = 1'b0;
   assign sda_oe_o = r_q.sda_drv;
   assign dec_o    = r_q.dec;

   always_comb
   begin
      cfg_o.speed_detect_enable            = r_q.cfg[ISDC_DET_EN_POS];
      cfg_o.brake_enable                   = r_q.cfg[ISDC_BRK_EN_POS];
      cfg_o.start_coast_enable             = r_q.cfg[ISDC_COAST_EN_POS];
      cfg_o.reverse_drive_enable           = r_q.cfg[ISDC_REV_EN_POS];
      cfg_o.resynchronize_enable           = r_q.cfg[ISDC_RSY_EN_POS];
      cfg_o.resync_speed_threshold         = r_q.cfg[ISDC_RSY_THR_LSB +: 4];
      cfg_o.current_sample_blanking        = r_q.cfg[ISDC_BLANK_LSB +: 4];
      cfg_o.start_brake_duration           = r_q.cfg[ISDC_START_BRAKE_DURATION_LSB +: 4];
      cfg_o.start_coast_duration           = r_q.cfg[ISDC_CST_TIME_LSB +: 4];
      cfg_o.stationary_emf_threshold       = r_q.cfg[ISDC_EMF_THR_LSB +: 3];
      cfg_o.reverse_openloop_handoff_speed = r_q.cfg[ISDC_HAND_LSB +: 4];
      cfg_o.reverse_openloop_current_limit = r_q.cfg[ISDC_CUR_LSB +: 2];
   end

endmodule

// ==== verif/isdc_checker.sv ====
// assertions on the speed detect configuration bank
module isdc_checker (
   input wire logic                sys_clk_i,
   input wire logic                reset_i,
   input wire isdc_pkg::isdc_pin_t i2c_i,
   input wire logic                sda_o,
   input wire logic                sda_oe_o,
   input wire isdc_pkg::isdc_cfg_t cfg_o,
   input wire isdc_pkg::isdc_dec_t dec_o
);
   import isdc_pkg::*;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // ----
   // sequences and properties
   // ----
   sequence s_left_reset;
      $fell(reset_i);
   endsequence
   sequence s_bus_idle;
      i2c_i.scl && i2c_i.sda;
   endsequence
   property p_reset;
      s_left_reset |-> cfg_o == '0 && !sda_oe_o;
   endproperty
   a_reset: assert property (p_reset) else $error("cfg not cleared by reset");
   property p_cfg_idle;
      $changed(cfg_o) |-> s_bus_idle;
   endproperty
   a_cfg_idle: assert property (p_cfg_idle) else $error("cfg changed mid frame");
   property p_oe_scl;
      $changed(sda_oe_o) |-> !i2c_i.scl;
   endproperty
   a_oe_scl: assert property (p_oe_scl) else $error("data moved while clock high");
   property p_drain;
      sda_o == 1'h0;
   endproperty
   a_drain: assert property (p_drain) else $error("data pin driven high");
   property p_brake;
      dec_o.brake_ms == ISDC_TIME_MS[cfg_o.start_brake_duration];
   endproperty
   a_brake: assert property (p_brake) else $error("brake decode wrong");
   property p_coast;
      dec_o.coast_ms == ISDC_TIME_MS[cfg_o.start_coast_duration];
   endproperty
   a_coast: assert property (p_coast) else $error("coast decode wrong");
   property p_emf;
      dec_o.stationary_mv == ISDC_EMF_MV[cfg_o.stationary_emf_threshold];
   endproperty
   a_emf: assert property (p_emf) else $error("emf decode wrong");
   property p_resync;
      dec_o.resync_pct == ISDC_RSY_PCT[cfg_o.resync_speed_threshold];
   endproperty
   a_resync: assert property (p_resync) else $error("resync decode wrong");
   property p_handoff;
      dec_o.handoff_permil == ISDC_HAND_PERMIL[cfg_o.reverse_openloop_handoff_speed];
   endproperty
   a_handoff: assert property (p_handoff) else $error("handoff decode wrong");
   property p_current;
      dec_o.current_pct == ISDC_CUR_PCT[cfg_o.reverse_openloop_current_limit];
   endproperty
   a_current: assert property (p_current) else $error("current decode wrong");
endmodule

bind isdc_top isdc_checker u_checker (
   .sys_clk_i (sys_clk_i),
   .reset_i   (reset_i),
   .i2c_i     (i2c_i),
   .sda_o     (sda_o),
   .sda_oe_o  (sda_oe_o),
   .cfg_o     (cfg_o),
   .dec_o     (dec_o)
);

// ==== verif/isdc_host.sv ====
// two-wire host that frames register accesses
module isdc_host (
   input  wire logic sys_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int H = 10;
   initial
   begin
      scl_o = 1'h1;
      sda_o = 1'h1;
   end
   // ----
   // bit and byte level
   // ----
   task automatic hw();
      repeat (H) @(posedge sys_clk_i);
   endtask
   task automatic start();
      sda_o <= 1'h1;
      hw();
      scl_o <= 1'h1;
      hw();
      sda_o <= 1'h0;
      hw();
      scl_o <= 1'h0;
      hw();
   endtask
   task automatic stop();
      sda_o <= 1'h0;
      hw();
      scl_o <= 1'h1;
      hw();
      sda_o <= 1'h1;
      hw();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_o <= b;
      hw();
      scl_o <= 1'h1;
      hw();
      r = sda_i;
      scl_o <= 1'h0;
      hw();
   endtask
   task automatic xfer(input logic [7:0] tx, input logic nack, output logic [7:0] rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(nack, r);
      ack = !r;
   endtask
   function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      repeat (8) x = x[7] ? {x[6:0], 1'h0} ^ 8'h07 : {x[6:0], 1'h0};
      return x;
   endfunction
   task automatic snd(input logic [7:0] b, inout logic [7:0] c, inout logic ok);
      logic [7:0] rx;
      logic       a;
      xfer(b, 1'h1, rx, a);
      ok = ok & a;
      c = crc(c, b);
   endtask
   // ----
   // frames, register 80h only
   // ----
   task automatic wr(input logic [31:0] d, input logic [7:0] c0, input logic [7:0] bad, output logic ok);
      logic [7:0] c;
      c = 8'h00;
      ok = 1'h1;
      start();
      snd(8'h02, c, ok);
      snd(c0, c, ok);
      snd(8'h00, c, ok);
      snd(8'h80, c, ok);
      for (int i = 0; i < 4; i++)
         snd(d[8*i +: 8], c, ok);
      if (c0[6])
         snd(c ^ bad, c, ok);
      stop();
   endtask
   task automatic rd(input logic ce, output logic [31:0] d, output logic [7:0] k, output logic [7:0] e,
      output logic ok);
      logic [7:0] c;
      logic [7:0] rx;
      logic       a;
      c = 8'h00;
      ok = 1'h1;
      k = 8'hFF;
      start();
      snd(8'h02, c, ok);
      snd(ce ? 8'hD0 : 8'h90, c, ok);
      snd(8'h00, c, ok);
      snd(8'h80, c, ok);
      start();
      snd(8'h03, c, ok);
      for (int i = 0; i < 4; i++)
      begin
         xfer(8'hFF, i == 3 && !ce, rx, a);
         d[8*i +: 8] = rx;
         c = crc(c, rx);
      end
      if (ce)
         xfer(8'hFF, 1'h1, k, a);
      e = c;
      stop();
   endtask
endmodule

// ==== verif/isdc_top_test.sv ====
// self-checking bench for the speed detect configuration bank
module isdc_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   import isdc_pkg::*;
   localparam int MS [16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 2000, 3000, 4000, 5000, 7500,
      10000, 15000};
   localparam int RSY [16] = '{5, 10, 15, 20, 25, 30, 35, 40, 45, 50, 55, 60, 70, 80, 90, 100};
   localparam int HND [16] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 400, 500, 600, 700, 800, 900, 1000};
   localparam int MV [8] = '{100, 150, 200, 500, 1000, 1500, 2000, 3000};
   localparam int CUR [4] = '{15, 25, 35, 50};
   logic        sys_clk_i = 1'h0;
   logic        reset_i = 1'h1;
   logic        scl_h;
   logic        sda_h;
   logic        sda_oe;
   isdc_pin_t   pins;
   isdc_cfg_t   cfg;
   isdc_dec_t   dec;
   int          fails = 0;
   int          checked = 0;
   logic [31:0] d;
   logic [7:0]  k;
   logic [7:0]  e;
   logic        ok;
   assign pins = {scl_h, sda_h & !sda_oe};
   always #10 sys_clk_i = ~sys_clk_i;
   isdc_top #(.TARGET_ID(7'h01)) uut (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .i2c_i     (pins),
      .sda_o     (),
      .sda_oe_o  (sda_oe),
      .cfg_o     (cfg),
      .dec_o     (dec)
   );
   isdc_host host (
      .sys_clk_i (sys_clk_i),
      .sda_i     (pins.sda),
      .scl_o     (scl_h),
      .sda_o     (sda_h)
   );
   // ----
   // helpers
   // ----
   function automatic logic [29:0] fld(input logic [31:0] v);
      return {v[30:22], v[20:0]};
   endfunction
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_reset();
      chk("cfg", 64'h0, cfg);
      chk("dec", {14'h000A, 14'h000A, 12'h064, 7'h05, 10'h019, 6'h0F}, dec);
      host.rd(1'h0, d, k, e, ok);
      chk("read", 64'h0, d);
      $display("reset test done");
   endtask
   task automatic t_codes();
      logic [31:0] v;
      for (int c = 0; c < 16; c++)
      begin
         v = {1'h0, 5'h00, 4'(c), 1'h0, 4'(c), 4'(c), 4'(c), 3'(c), 4'(c), 2'(c)};
         v[30 - c % 5] = 1'h1;
         host.wr(v, 8'h10, 8'h00, ok);
         chk("cfg", fld(v), cfg);
         chk("brake", MS[c], dec.brake_ms);
         chk("coast", MS[c], dec.coast_ms);
         chk("emf", MV[c % 8], dec.stationary_mv);
         chk("resync", RSY[c], dec.resync_pct);
         chk("handoff", HND[c], dec.handoff_permil);
         chk("current", CUR[c % 4], dec.current_pct);
      end
      $display("code test done");
   endtask
   task automatic t_mask();
      host.wr(32'hFFFFFFFF, 8'h10, 8'h00, ok);
      chk("ack", 64'h1, ok);
      chk("cfg", fld(32'hFFFFFFFF), cfg);
      chk("dec", {14'h3A98, 14'h3A98, 12'hBB8, 7'h64, 10'h3E8, 6'h32}, dec);
      host.rd(1'h1, d, k, e, ok);
      chk("read", 64'h7FDFFFFF, d);
      chk("crc", e, k);
      $display("mask test done");
   endtask
   task automatic t_refuse();
      host.wr(32'h12345678, 8'h50, 8'h01, ok);
      chk("cfg", fld(32'hFFFFFFFF), cfg);
      host.wr(32'h12345678, 8'h30, 8'h00, ok);
      chk("cfg", fld(32'hFFFFFFFF), cfg);
      host.wr(32'h12345678, 8'h00, 8'h00, ok);
      chk("cfg", fld(32'hFFFFFFFF), cfg);
      host.wr(32'h12345678, 8'h50, 8'h00, ok);
      chk("cfg", fld(32'h12345678), cfg);
      host.rd(1'h0, d, k, e, ok);
      chk("ack", 64'h1, ok);
      chk("read", 64'h12145678, d);
      host.start();
      host.xfer(8'h03, 1'h1, k, ok);
      host.stop();
      chk("read ack", 64'h0, ok);
      host.start();
      host.xfer(8'h04, 1'h1, k, ok);
      host.stop();
      chk("id ack", 64'h0, ok);
      reset_i <= 1'h1;
      repeat (3) @(posedge sys_clk_i);
      reset_i <= 1'h0;
      repeat (4) @(posedge sys_clk_i);
      chk("cfg", 64'h0, cfg);
      $display("refusal test done");
   endtask
   initial
   begin
      repeat (3) @(posedge sys_clk_i);
      reset_i <= 1'h0;
      repeat (4) @(posedge sys_clk_i);
      t_reset();
      t_codes();
      t_mask();
      t_refuse();
      conclude();
   end
   initial
   begin
      repeat (100000) @(posedge sys_clk_i);
      fails++;
      conclude();
   end
endmodule
